// [src/rpm_params.svh]
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

// register byte offsets
`define RPM_CTRL_OFS 8'h00
`define RPM_STAT_OFS 8'h04
`define RPM_CAUSE_OFS 8'h08
// ctrl fields
`define RPM_CTRL_MON_EN 0
`define RPM_CTRL_SWRST 1
// reset values of the cpu state
`define RPM_PC_RST 10'h000
`define RPM_SP_RST 1'b0
`define RPM_DP_RST 8'h00
`define RPM_TMR_RST 10'h000
`define RPM_KEYOUT_RST 8'hff
`define RPM_KEYIN_LOW_RST 4'hf
`define RPM_CTL_LOW_RST 8'h03
`define RPM_CTL_HIGH_RST 8'h26
// timing
`define RPM_CLK_HZ 25000000
`define RPM_STAB_MIN_FX 246
`define RPM_STAB_MAX_FX 694
`define RPM_MON_DIP_US 1000
`define RPM_MON_DIP_CYC ((`RPM_MON_DIP_US * (`RPM_CLK_HZ / 1000000)))

`endif

// [src/rpm_pkg.sv]
package rpm_pkg;
    typedef enum logic [1:0] {
        RPM_HOLD = 2'b00,
        RPM_WAIT = 2'b01,
        RPM_RUN = 2'b11
    } rpm_state_type;

    typedef struct packed {
        logic halt_bad;
        logic rotate_zero;
        logic stack_ovf;
        logic stack_unf;
    } rpm_int_src_type;

    typedef struct packed {
        logic [9:0] program_counter;
        logic stack_pointer;
        logic [7:0] data_pointer;
        logic flag;
        logic carry_bit;
        logic [9:0] timer;
        logic [7:0] key_output_latch;
        logic [3:0] key_input_low;
        logic [7:0] control_reg_low;
        logic [7:0] control_reg_high;
    } rpm_cpu_init_type;

    typedef struct packed {
        rpm_state_type state;
        logic [15:0] stab_cnt;
        logic [15:0] dip_cnt;
        logic mon_rst;
        logic [4:0] cause;
        logic mon_en;
        logic swrst;
        logic sby_at_rst;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
    } rpm_state_all_type;
endpackage

// [src/rpm_reset_monitor.sv]
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rpm_params.svh"

module rpm_reset_monitor
    import rpm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic supply_below_trip,
    input wire logic in_standby,
    input wire rpm_int_src_type int_src,
    output logic osc_run,
    output logic osc_in_pin_gnd,
    output logic osc_out_pin_gnd,
    output logic cpu_reset,
    output logic scratch_regs_keep,
    output rpm_cpu_init_type cpu_init
);
    localparam logic [15:0] STAB_CYC = 16'(`RPM_STAB_MIN_FX);
    localparam logic [15:0] DIP_CYC = 16'(`RPM_MON_DIP_CYC);

    rpm_state_all_type st_reg;
    rpm_state_all_type st_next;

    logic int_any;
    logic mon_req;
    logic any_rst;
    logic aw_go;
    logic w_go;
    logic wr_do;
    logic rd_do;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;

    assign int_any = |int_src;
    // monitor gated by its enable, reset pin sampled directly
    assign mon_req = st_reg.mon_en & supply_below_trip;
    assign any_rst = ~reset_pin_in | st_reg.mon_rst | int_any | st_reg.swrst;

    assign aw_go = s_axi_awvalid & ~st_reg.aw_held;
    assign w_go = s_axi_wvalid & ~st_reg.w_held;
    assign wr_do = (st_reg.aw_held | aw_go) & (st_reg.w_held | w_go) & ~st_reg.bvalid;
    assign rd_do = s_axi_arvalid & ~st_reg.rvalid;
    assign wr_addr = aw_go ? s_axi_awaddr : st_reg.awaddr;
    assign wr_data = w_go ? s_axi_wdata : st_reg.wdata;

    always_comb begin
        st_next = st_reg;
        st_next.swrst = 1'b0;
        // dip filter: assert after a full 1 ms below trip, release at once
        if (mon_req) begin
            if (st_reg.dip_cnt >= DIP_CYC - 16'h0001) begin
                st_next.mon_rst = 1'b1;
            end else begin
                st_next.dip_cnt = st_reg.dip_cnt + 16'h0001;
            end
        end else begin
            st_next.dip_cnt = 16'h0000;
            st_next.mon_rst = 1'b0;
        end
        case (st_reg.state)
            RPM_HOLD: begin
                if (!any_rst) begin
                    st_next.state = RPM_WAIT;
                    st_next.stab_cnt = 16'h0000;
                end
            end
            RPM_WAIT: begin
                if (any_rst) begin
                    st_next.state = RPM_HOLD;
                end else if (st_reg.stab_cnt >= STAB_CYC - 16'h0001) begin
                    st_next.state = RPM_RUN;
                end else begin
                    st_next.stab_cnt = st_reg.stab_cnt + 16'h0001;
                end
            end
            RPM_RUN: begin
                if (any_rst) begin
                    st_next.state = RPM_HOLD;
                    st_next.sby_at_rst = in_standby;
                end
            end
            default: st_next.state = RPM_HOLD;
        endcase
        // cause bits: set wins over a clear by write
        if (wr_do && wr_addr == `RPM_CAUSE_OFS && s_axi_wstrb[0]) begin
            st_next.cause = st_reg.cause & ~wr_data[4:0];
        end
        st_next.cause = st_next.cause | {~reset_pin_in, st_reg.mon_rst, int_src.halt_bad,
            int_src.rotate_zero, int_src.stack_ovf | int_src.stack_unf};
        // bus capture
        if (aw_go) begin
            st_next.aw_held = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (w_go) begin
            st_next.w_held = 1'b1;
            st_next.wdata = s_axi_wdata;
        end
        if (wr_do) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = 2'b00;
            case (wr_addr)
                `RPM_CTRL_OFS: begin
                    if (s_axi_wstrb[0]) begin
                        st_next.mon_en = wr_data[`RPM_CTRL_MON_EN];
                        st_next.swrst = wr_data[`RPM_CTRL_SWRST];
                    end
                end
                `RPM_CAUSE_OFS: st_next.bresp = 2'b00;
                default: st_next.bresp = 2'b10;
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (rd_do) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = 2'b00;
            case (s_axi_araddr)
                `RPM_CTRL_OFS: st_next.rdata = {30'h0, 1'b0, st_reg.mon_en};
                `RPM_STAT_OFS: st_next.rdata = {28'h0, st_reg.sby_at_rst, st_reg.mon_rst,
                    st_reg.state};
                `RPM_CAUSE_OFS: st_next.rdata = {27'h0, st_reg.cause};
                default: begin
                    st_next.rdata = 32'h0;
                    st_next.rresp = 2'b10;
                end
            endcase
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.mon_en <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = ~st_reg.aw_held;
    assign s_axi_wready = ~st_reg.w_held;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = ~st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = st_reg.mon_rst;
    assign cpu_reset = (st_reg.state != RPM_RUN);
    assign osc_run = (st_reg.state != RPM_HOLD);
    assign osc_in_pin_gnd = ~osc_run;
    assign osc_out_pin_gnd = ~osc_run;
    assign scratch_regs_keep = st_reg.sby_at_rst;

    always_comb begin
        cpu_init.program_counter = `RPM_PC_RST;
        cpu_init.stack_pointer = `RPM_SP_RST;
        cpu_init.data_pointer = `RPM_DP_RST;
        cpu_init.flag = 1'b0;
        cpu_init.carry_bit = 1'b0;
        cpu_init.timer = `RPM_TMR_RST;
        cpu_init.key_output_latch = `RPM_KEYOUT_RST;
        cpu_init.key_input_low = `RPM_KEYIN_LOW_RST;
        cpu_init.control_reg_low = `RPM_CTL_LOW_RST;
        cpu_init.control_reg_high = `RPM_CTL_HIGH_RST;
    end

    sequence s_released;
        st_reg.state == RPM_HOLD ##1 st_reg.state == RPM_WAIT;
    endsequence

    a_wait_min_count: assert property (@(posedge aclk) disable iff (!aresetn)
        s_released |-> cpu_reset [*8])
        else $error("run began too soon after release");
    a_pin_low_resets: assert property (@(posedge aclk) disable iff (!aresetn)
        !reset_pin_in |=> cpu_reset)
        else $error("low reset pin did not hold reset");
    a_osc_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!reset_pin_in) && !reset_pin_in |-> !osc_run && osc_in_pin_gnd)
        else $error("oscillator running while pin low");
    a_mon_drives_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.mon_rst |-> reset_pin_oe && !reset_pin_out)
        else $error("monitor reset not on pin");
    a_mon_release: assert property (@(posedge aclk) disable iff (!aresetn)
        !mon_req |=> !st_reg.mon_rst)
        else $error("monitor reset held above trip");
    a_dip_filter: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.mon_rst) |-> $past(mon_req, 8))
        else $error("monitor fired on short dip");
    a_internal_src: assert property (@(posedge aclk) disable iff (!aresetn)
        int_any |=> cpu_reset)
        else $error("internal source did not reset");
    a_run_after_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_RUN && $past(st_reg.state) == RPM_WAIT |-> $past(st_reg.stab_cnt)
        == STAB_CYC - 16'h0001)
        else $error("stabilization count wrong");

    a_pin_drive_low: assert property (@(posedge aclk) disable iff (!aresetn)
        reset_pin_oe |-> !reset_pin_out)
        else $error("reset pin enabled but not low");

    a_mon_or_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.mon_rst && st_reg.state == RPM_RUN |=> cpu_reset)
        else $error("monitor alone did not reset");

    a_osc_pins_gnd: assert property (@(posedge aclk) disable iff (!aresetn)
        !osc_run |-> osc_in_pin_gnd && osc_out_pin_gnd)
        else $error("oscillator pins not grounded");

    a_hold_osc_off: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_HOLD |-> !osc_run)
        else $error("oscillator running in hold");

    a_init_pc_sp: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_init.program_counter == 10'h000 && cpu_init.stack_pointer == 1'b0)
        else $error("program counter or stack pointer not cleared");

    a_init_dp_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_init.data_pointer == 8'h00 && !cpu_init.flag && !cpu_init.carry_bit)
        else $error("data pointer or flags not cleared");

    a_init_timer: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_init.timer == 10'h000)
        else $error("timer not cleared");

    a_init_key_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_init.key_output_latch == 8'hff && cpu_init.key_input_low == 4'hf)
        else $error("key latches not preset");

    a_init_ctl_regs: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_init.control_reg_low == 8'h03 && cpu_init.control_reg_high == 8'h26)
        else $error("control registers not preset");

    a_halt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        int_src.halt_bad |=> cpu_reset)
        else $error("bad standby did not reset");

    a_rotate_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        int_src.rotate_zero |=> cpu_reset)
        else $error("zero rotate did not reset");

    a_stack_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        int_src.stack_ovf || int_src.stack_unf |=> cpu_reset)
        else $error("stack fault did not reset");

    a_wait_in_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_WAIT |-> cpu_reset && osc_run)
        else $error("wait state not holding core");

    a_stab_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_WAIT |-> st_reg.stab_cnt < STAB_CYC)
        else $error("stabilization counter overran");

    a_hold_while_src: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_HOLD && any_rst |=> st_reg.state == RPM_HOLD)
        else $error("left hold with a source active");

    a_wait_abort: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_WAIT && any_rst |=> st_reg.state == RPM_HOLD)
        else $error("wait not restarted by new reset");

    a_keep_standby: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.state == RPM_RUN && any_rst |=> scratch_regs_keep == $past(in_standby))
        else $error("scratch keep does not match standby");

    a_dip_count: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.mon_rst) |-> $past(st_reg.dip_cnt) == DIP_CYC - 16'h0001)
        else $error("monitor fired before full dip time");

    a_mon_set: assert property (@(posedge aclk) disable iff (!aresetn)
        mon_req && st_reg.dip_cnt == DIP_CYC - 16'h0001 |=> st_reg.mon_rst)
        else $error("monitor did not fire below trip");

    a_cause_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        int_src.halt_bad |=> st_reg.cause[2])
        else $error("standby cause not recorded");

    a_cause_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        !reset_pin_in |=> st_reg.cause[4])
        else $error("pin cause not recorded");

    a_pin_low_osc: assert property (@(posedge aclk) disable iff (!aresetn)
        !reset_pin_in && st_reg.state == RPM_RUN |=> !osc_run)
        else $error("oscillator not stopped by pin");

    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.bvalid && !s_axi_bready |=> st_reg.bvalid)
        else $error("write response dropped early");

    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.rvalid && !s_axi_rready |=> st_reg.rvalid)
        else $error("read response dropped early");

    sequence s_entered_run;
        st_reg.state == RPM_WAIT ##1 st_reg.state == RPM_RUN;
    endsequence
    a_run_clean: assert property (@(posedge aclk) disable iff (!aresetn)
        s_entered_run |-> !cpu_reset && osc_run)
        else $error("run entered with core held");

    sequence s_run_left;
        st_reg.state == RPM_RUN ##1 st_reg.state == RPM_HOLD;
    endsequence
    a_left_run: assert property (@(posedge aclk) disable iff (!aresetn)
        s_run_left |-> cpu_reset && !osc_run)
        else $error("hold entered without reset");

    sequence s_mon_fired;
        !st_reg.mon_rst ##1 st_reg.mon_rst;
    endsequence
    a_mon_fired_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        s_mon_fired |-> reset_pin_oe)
        else $error("monitor reset not driven on pin");
endmodule // rpm_reset_monitor
`default_nettype wire

// [tb/rpm_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module rpm_partner (
    input wire logic ext_low,
    input wire logic dip,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    output logic reset_pin_in,
    output logic supply_below_trip,
    output logic [3:0] key_pins
);
    // two key inputs kept low so every reset release is safe
    assign key_pins = 4'h5;
    // pulled-up open-drain line, low if either party sinks it
    assign reset_pin_in = ~(ext_low | (reset_pin_oe & ~reset_pin_out));
    assign supply_below_trip = dip;
endmodule // rpm_partner
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rpm_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic ext_low = 0, dip = 0, sby = 0;
    rpm_int_src_type isrc = '0;
    logic aw_rdy, w_rdy, bv, ar_rdy, rv, pin, oe, pout, below, osc, ig, og, crst, keep;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [3:0] keys;
    rpm_cpu_init_type ci;
    int err_total = 0, samples_checked = 0, cyc = 0, n;
    logic [33:0] exq[$];
    integer seed = 32'h21468d95;

    rpm_reset_monitor i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(aw_rdy),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .reset_pin_in(pin),
        .reset_pin_out(pout), .reset_pin_oe(oe), .supply_below_trip(below),
        .in_standby(sby), .int_src(isrc), .osc_run(osc), .osc_in_pin_gnd(ig),
        .osc_out_pin_gnd(og), .cpu_reset(crst), .scratch_regs_keep(keep), .cpu_init(ci)
    );
    rpm_partner i_far (
        .ext_low(ext_low), .dip(dip), .reset_pin_out(pout), .reset_pin_oe(oe),
        .reset_pin_in(pin), .supply_below_trip(below), .key_pins(keys)
    );

    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ta = 0;
        logic tw = 0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta | aw_rdy;
            tw = tw | w_rdy;
            @(posedge aclk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        while (bv !== 1'b1) @(negedge aclk);
        chk("bresp", e, br);
        @(posedge aclk);
        bre <= 0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] ed);
        @(posedge aclk);
        ara <= a;
        arv <= 1;
        rre <= 1;
        exq.push_back({e, ed});
        do @(negedge aclk); while (ar_rdy !== 1'b1);
        @(posedge aclk);
        arv <= 0;
        while (rv !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        rre <= 0;
    endtask

    // read results are matched against the oldest expectation
    always @(negedge aclk) begin
        if (rv === 1'b1 && rre && exq.size() > 0) chk("rdata", exq.pop_front(), {rr, rd});
    end

    task automatic run_cnt(input string nm, input int lo, input int hi);
        n = 0;
        while (crst !== 1'b0 && n < 1000) begin
            @(negedge aclk);
            n++;
        end
        chk(nm, 1, n >= lo && n <= hi);
        chk("osc_run", 1, osc);
        $display("test %s done after %0d cycles", nm, n);
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        chk("hold_state", 4'b1011, {crst, osc, ig, og});
        chk("cpu_init", {10'h000, 1'b0, 8'h00, 2'b00, 10'h000, 8'hff, 4'hf, 16'h0326}, ci);
        run_cnt("power_on", 246, 694);
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk);
            ext_low <= 1;
            sby <= k[0];
            repeat (2) @(negedge aclk);
            chk("pin_hold", 4'b1011, {crst, osc, ig, og});
            repeat (2 + ($unsigned($random(seed)) % 20)) @(posedge aclk);
            ext_low <= 0;
            sby <= 0;
            chk("scratch_keep", k[0], keep);
            chk("key_low", 1, $countones(~keys) > 1);
            run_cnt("pin_release", 246, 694);
        end
        axi_wr(8'h08, 32'h1f, 2'b00);
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            isrc <= rpm_int_src_type'(4'h1 << i);
            @(posedge aclk);
            isrc <= '0;
            @(negedge aclk);
            chk("int_reset", 1, crst);
            run_cnt("int_release", 246, 694);
            axi_rd(8'h08, 2'b00, (i < 2) ? 32'h1 : (32'h1 << (i - 1)));
            axi_wr(8'h08, 32'h1f, 2'b00);
        end
        @(posedge aclk);
        dip <= 1;
        repeat (200) @(posedge aclk);
        dip <= 0;
        @(negedge aclk);
        chk("short_dip", 2'b00, {oe, crst});
        @(posedge aclk);
        dip <= 1;
        repeat (25010) @(posedge aclk);
        @(negedge aclk);
        chk("long_dip", 3'b101, {oe, pin, crst});
        axi_rd(8'h04, 2'b00, 32'h4);
        @(posedge aclk);
        dip <= 0;
        run_cnt("monitor_release", 246, 700);
        chk("oe_drop", 0, oe);
        axi_rd(8'h04, 2'b00, 32'h3);
        axi_rd(8'h0c, 2'b10, 32'h0);
        axi_wr(8'h04, 32'h0, 2'b10);
        axi_wr(8'h00, 32'h0, 2'b00);
        axi_rd(8'h00, 2'b00, 32'h0);
        axi_wr(8'h00, 32'h3, 2'b00);
        @(negedge aclk);
        chk("soft_reset", 1, crst);
        run_cnt("soft_release", 246, 694);
        axi_rd(8'h00, 2'b00, 32'h1);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
